// [hdl/sltr_pkg.sv]
// constants for the per-serdes lane tuning register bank
// assumes eight serdes blocks of four lanes each, one clock, plain register port
//
// Operation
// - a write to a per-lane transmit or receive tuning register lands only in the lanes picked by the four-bit lane pick field of that serdes.
// - every stored tuning value is kept for every lane, picked or not, and is cleared only by the retained reset.
// - the three-bit coarse de-emphasis at bits 15:13, reset 0x3, drives the gen 2 full-swing transmitter when -3.5dB is selected.
// - the five-bit level at bits 20:16, reset 0x15, sets the gen 2 full-swing level when -6.0dB is selected.
// - the three-bit coarse de-emphasis at bits 23:21, reset 0x6, drives gen 2 full-swing de-emphasis when -6.0dB is selected.
// - coarse de-emphasis values are ignored and de-emphasis is off while the port is in low-swing mode.
// - the four-bit level at bits 27:24, reset 0xA, sets the transmit level in low-swing mode at gen 1.
// - the four-bit level at bits 31:28, reset 0xC, sets the transmit level in low-swing mode at gen 2.
// - the equalizer zero control sits at bits 2:0, resets to 0x1, and 0x7 gives the most high-frequency gain.
// - the equalizer boost control sits at bits 5:3, resets to 0x7, the least low-frequency gain and most boost.
// - with zero and boost both zero, receiver equalization of that lane is switched off completely.
// - each of the eight serdes blocks has its own transmit lane control and receiver equalization registers.

package sltr_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_SD       = 8;
  localparam int LANES_PER_SD = 4;
  localparam int NUM_LANES    = NUM_SD * LANES_PER_SD;
  localparam int LANE_IDX_W   = 2;
  localparam int SD_IDX_W     = 3;

  // ----------------------------------------------------------------
  // register map: one 16-byte slot per serdes
  // ----------------------------------------------------------------
  localparam int             ADDR_W     = 8;
  localparam int             DATA_W     = 32;
  localparam int             SD_IDX_LSB = 4;
  localparam int             OFS_W      = 4;
  localparam logic [3:0]     OFS_CTL    = 4'h0;
  localparam logic [3:0]     OFS_TX     = 4'h4;
  localparam logic [3:0]     OFS_RX     = 4'h8;
  localparam int             TOP_BIT    = 7;

  // serdes control: lane pick field
  localparam int             PICK_LSB   = 0;
  localparam int             PICK_W     = 4;
  localparam logic [3:0]     RST_PICK   = 4'hF;

  // ----------------------------------------------------------------
  // transmit lane control one fields
  // ----------------------------------------------------------------
  localparam int LVL3G1_LSB = 0;
  localparam int CDC3G1_LSB = 5;
  localparam int LVL3G2_LSB = 8;
  localparam int CDC3G2_LSB = 13;
  localparam int LVL6_LSB   = 16;
  localparam int CDC6_LSB   = 21;
  localparam int LSG1_LSB   = 24;
  localparam int LSG2_LSB   = 28;
  localparam int LVL_W      = 5;
  localparam int CDC_W      = 3;
  localparam int LS_W       = 4;

  localparam logic [4:0] RST_LVL3G1 = 5'h12;
  localparam logic [2:0] RST_CDC3G1 = 3'h3;
  localparam logic [4:0] RST_LVL3G2 = 5'h18;
  localparam logic [2:0] RST_CDC3G2 = 3'h3;
  localparam logic [4:0] RST_LVL6   = 5'h15;
  localparam logic [2:0] RST_CDC6   = 3'h6;
  localparam logic [3:0] RST_LSG1   = 4'hA;
  localparam logic [3:0] RST_LSG2   = 4'hC;

  localparam logic [31:0] RST_TX = {RST_LSG2, RST_LSG1, RST_CDC6, RST_LVL6,
                                    RST_CDC3G2, RST_LVL3G2, RST_CDC3G1, RST_LVL3G1};

  // ----------------------------------------------------------------
  // receiver equalization lane control fields
  // ----------------------------------------------------------------
  localparam int         EQZ_LSB = 0;
  localparam int         EQB_LSB = 3;
  localparam int         EQ_W    = 3;
  localparam int         RX_W    = 6;
  localparam logic [2:0] RST_EQZ = 3'h1;
  localparam logic [2:0] RST_EQB = 3'h7;
  localparam logic [2:0] EQ_OFF  = 3'h0;
  localparam logic [5:0] RST_RX  = {RST_EQB, RST_EQZ};

  localparam logic [2:0] CDC_OFF = 3'h0;

endpackage : sltr_pkg

// [hdl/sltr_lane_store.sv]
// storage of one lane's transmit and receive tuning words
// assumes write enables are already qualified by the lane pick
`timescale 1ns/1ps

module sltr_lane_store (
  clk_sys,
  rst_n,
  wr_tx,
  wr_rx,
  wdata,
  tx_q,
  rx_q
);
  input  wire logic                       clk_sys;
  input  wire logic                       rst_n;
  input  wire logic                       wr_tx;
  input  wire logic                       wr_rx;
  input  wire logic [sltr_pkg::DATA_W-1:0] wdata;
  output logic      [sltr_pkg::DATA_W-1:0] tx_q;
  output logic      [sltr_pkg::RX_W-1:0]   rx_q;

  logic [sltr_pkg::DATA_W-1:0] tx_ff;
  logic [sltr_pkg::RX_W-1:0]   rx_ff;

  // ----------------------------------------------------------------
  // retained words: unpicked lanes simply keep their value
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_ff <= sltr_pkg::RST_TX;
      rx_ff <= sltr_pkg::RST_RX;
    end
    else
    begin
      if (wr_tx)
        tx_ff <= wdata;
      if (wr_rx)
        rx_ff <= wdata[sltr_pkg::RX_W-1:0];
    end
  end

  assign tx_q = tx_ff;
  assign rx_q = rx_ff;

endmodule : sltr_lane_store

// [hdl/sltr_regs.sv]
// lane tuning register bank for eight serdes blocks of four lanes
// assumes port mode flags come from logic on clk_sys; the analog side samples the tuning outputs
`timescale 1ns/1ps

module sltr_regs (
  clk_sys,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  port_low_swing_en,
  port_deemph_6db,
  port_gen2,
  tx_level,
  tx_deemph,
  rx_eq_zero,
  rx_eq_boost,
  rx_eq_en
);
  input  wire logic                                         clk_sys;
  input  wire logic                                         rst_n;
  input  wire logic [sltr_pkg::ADDR_W-1:0]                  reg_addr;
  input  wire logic [sltr_pkg::DATA_W-1:0]                  reg_wdata;
  input  wire logic                                         reg_wr;
  input  wire logic                                         reg_rd;
  output logic      [sltr_pkg::DATA_W-1:0]                  reg_rdata;
  input  wire logic [sltr_pkg::NUM_SD-1:0]                  port_low_swing_en;
  input  wire logic [sltr_pkg::NUM_SD-1:0]                  port_deemph_6db;
  input  wire logic [sltr_pkg::NUM_SD-1:0]                  port_gen2;
  output logic      [sltr_pkg::NUM_LANES*sltr_pkg::LVL_W-1:0] tx_level;
  output logic      [sltr_pkg::NUM_LANES*sltr_pkg::CDC_W-1:0] tx_deemph;
  output logic      [sltr_pkg::NUM_LANES*sltr_pkg::EQ_W-1:0]  rx_eq_zero;
  output logic      [sltr_pkg::NUM_LANES*sltr_pkg::EQ_W-1:0]  rx_eq_boost;
  output logic      [sltr_pkg::NUM_LANES-1:0]               rx_eq_en;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic [sltr_pkg::SD_IDX_W-1:0] sd_idx;
  wire logic [sltr_pkg::OFS_W-1:0]    ofs;
  wire logic                          in_range;
  wire logic                          hit_ctl;
  wire logic                          hit_tx;
  wire logic                          hit_rx;

  assign sd_idx   = reg_addr[sltr_pkg::SD_IDX_LSB +: sltr_pkg::SD_IDX_W];
  assign ofs      = reg_addr[0 +: sltr_pkg::OFS_W];
  assign in_range = ~reg_addr[sltr_pkg::TOP_BIT];
  assign hit_ctl  = in_range && (ofs == sltr_pkg::OFS_CTL);
  assign hit_tx   = in_range && (ofs == sltr_pkg::OFS_TX);
  assign hit_rx   = in_range && (ofs == sltr_pkg::OFS_RX);

  logic [sltr_pkg::PICK_W-1:0] pick_ff [sltr_pkg::NUM_SD];
  logic [sltr_pkg::DATA_W-1:0] tx_q    [sltr_pkg::NUM_LANES];
  logic [sltr_pkg::RX_W-1:0]   rx_q    [sltr_pkg::NUM_LANES];

  // ----------------------------------------------------------------
  // per-serdes control and per-lane storage
  // ----------------------------------------------------------------
  genvar gs;
  genvar gl;
  generate
    for (gs = 0; gs < sltr_pkg::NUM_SD; gs++)
    begin : g_sd
      // genvars take no part-select on every tool, so the index goes through an int constant
      localparam int SD = gs;
      wire logic wr_ctl;
      assign wr_ctl = reg_wr && hit_ctl && (sd_idx == SD[sltr_pkg::SD_IDX_W-1:0]);

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
          pick_ff[gs] <= sltr_pkg::RST_PICK;
        else if (wr_ctl)
          pick_ff[gs] <= reg_wdata[sltr_pkg::PICK_LSB +: sltr_pkg::PICK_W];
      end

      for (gl = 0; gl < sltr_pkg::LANES_PER_SD; gl++)
      begin : g_lane
        localparam int LN = gs * sltr_pkg::LANES_PER_SD + gl;
        wire logic sel;
        wire logic wr_tx;
        wire logic wr_rx;
        wire logic ls;
        wire logic [sltr_pkg::DATA_W-1:0] t;
        wire logic [sltr_pkg::LVL_W-1:0]  nxt_lvl;
        wire logic [sltr_pkg::CDC_W-1:0]  nxt_cdc;
        wire logic [sltr_pkg::LVL_W-1:0]  ls_lvl;
        wire logic [sltr_pkg::LVL_W-1:0]  fs_lvl;
        wire logic [sltr_pkg::CDC_W-1:0]  fs_cdc;
        wire logic [sltr_pkg::EQ_W-1:0]   eqz;
        wire logic [sltr_pkg::EQ_W-1:0]   eqb;
        logic [sltr_pkg::LVL_W-1:0] lvl_ff;
        logic [sltr_pkg::CDC_W-1:0] cdc_ff;
        logic [sltr_pkg::EQ_W-1:0]  eqz_ff;
        logic [sltr_pkg::EQ_W-1:0]  eqb_ff;
        logic                       eqen_ff;

        assign sel   = (sd_idx == SD[sltr_pkg::SD_IDX_W-1:0]) && pick_ff[gs][gl];
        assign wr_tx = reg_wr && hit_tx && sel;
        assign wr_rx = reg_wr && hit_rx && sel;

        sltr_lane_store u_store (
          .clk_sys (clk_sys),
          .rst_n   (rst_n),
          .wr_tx   (wr_tx),
          .wr_rx   (wr_rx),
          .wdata   (reg_wdata),
          .tx_q    (tx_q[LN]),
          .rx_q    (rx_q[LN])
        );

        // pick the active level and de-emphasis from the port's mode
        assign t  = tx_q[LN];
        assign ls = port_low_swing_en[gs];
        assign ls_lvl = port_gen2[gs]
                      ? {1'b0, t[sltr_pkg::LSG2_LSB +: sltr_pkg::LS_W]}
                      : {1'b0, t[sltr_pkg::LSG1_LSB +: sltr_pkg::LS_W]};
        assign fs_lvl = !port_gen2[gs]    ? t[sltr_pkg::LVL3G1_LSB +: sltr_pkg::LVL_W]
                      : port_deemph_6db[gs] ? t[sltr_pkg::LVL6_LSB +: sltr_pkg::LVL_W]
                      : t[sltr_pkg::LVL3G2_LSB +: sltr_pkg::LVL_W];
        assign fs_cdc = !port_gen2[gs]    ? t[sltr_pkg::CDC3G1_LSB +: sltr_pkg::CDC_W]
                      : port_deemph_6db[gs] ? t[sltr_pkg::CDC6_LSB +: sltr_pkg::CDC_W]
                      : t[sltr_pkg::CDC3G2_LSB +: sltr_pkg::CDC_W];
        assign nxt_lvl = ls ? ls_lvl : fs_lvl;
        assign nxt_cdc = ls ? sltr_pkg::CDC_OFF : fs_cdc;
        assign eqz     = rx_q[LN][sltr_pkg::EQZ_LSB +: sltr_pkg::EQ_W];
        assign eqb     = rx_q[LN][sltr_pkg::EQB_LSB +: sltr_pkg::EQ_W];

        // registered so the analog side never sees a decode glitch
        always_ff @(posedge clk_sys)
        begin
          if (!rst_n)
          begin
            lvl_ff  <= sltr_pkg::RST_LVL3G1;
            cdc_ff  <= sltr_pkg::RST_CDC3G1;
            eqz_ff  <= sltr_pkg::RST_EQZ;
            eqb_ff  <= sltr_pkg::RST_EQB;
            eqen_ff <= (sltr_pkg::RST_EQZ != sltr_pkg::EQ_OFF) || (sltr_pkg::RST_EQB != sltr_pkg::EQ_OFF);
          end
          else
          begin
            lvl_ff  <= nxt_lvl;
            cdc_ff  <= nxt_cdc;
            eqz_ff  <= eqz;
            eqb_ff  <= eqb;
            eqen_ff <= !((eqz == sltr_pkg::EQ_OFF) && (eqb == sltr_pkg::EQ_OFF));
          end
        end

        assign tx_level[LN*sltr_pkg::LVL_W +: sltr_pkg::LVL_W]   = lvl_ff;
        assign tx_deemph[LN*sltr_pkg::CDC_W +: sltr_pkg::CDC_W]  = cdc_ff;
        assign rx_eq_zero[LN*sltr_pkg::EQ_W +: sltr_pkg::EQ_W]   = eqz_ff;
        assign rx_eq_boost[LN*sltr_pkg::EQ_W +: sltr_pkg::EQ_W]  = eqb_ff;
        assign rx_eq_en[LN]                                      = eqen_ff;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // no lane picked falls back to lane 0 so a read is always defined
  function automatic logic [sltr_pkg::LANE_IDX_W-1:0] lowest_pick(input logic [sltr_pkg::PICK_W-1:0] p);
    logic [sltr_pkg::LANE_IDX_W-1:0] r;
    r = '0;
    for (int i = sltr_pkg::PICK_W - 1; i >= 0; i--)
      if (p[i])
        r = i[sltr_pkg::LANE_IDX_W-1:0];
    return r;
  endfunction : lowest_pick

  wire logic [sltr_pkg::PICK_W-1:0]                     cur_pick;
  wire logic [sltr_pkg::SD_IDX_W+sltr_pkg::LANE_IDX_W-1:0] rd_lane;
  wire logic [sltr_pkg::DATA_W-1:0]                     ctl_word;
  wire logic [sltr_pkg::DATA_W-1:0]                     rx_word;
  wire logic [sltr_pkg::DATA_W-1:0]                     nxt_rdata;
  logic      [sltr_pkg::DATA_W-1:0]                     rdata_ff;

  assign cur_pick  = pick_ff[sd_idx];
  assign rd_lane   = {sd_idx, lowest_pick(cur_pick)};
  assign ctl_word  = {{(sltr_pkg::DATA_W-sltr_pkg::PICK_W){1'b0}}, cur_pick};
  assign rx_word   = {{(sltr_pkg::DATA_W-sltr_pkg::RX_W){1'b0}}, rx_q[rd_lane]};
  assign nxt_rdata = hit_ctl ? ctl_word
                   : hit_tx  ? tx_q[rd_lane]
                   : hit_rx  ? rx_word
                   : '0;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else if (reg_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= '0;
  end

  assign reg_rdata = rdata_ff;

endmodule : sltr_regs

// [dv/sltr_regs_chk.sv]
// concurrent checks on the ports of the lane tuning register bank
// assumes one clock, synchronous active-low reset, bound into sltr_regs
`timescale 1ns/1ps

module sltr_regs_chk (
  input wire logic         clk_sys,
  input wire logic         rst_n,
  input wire logic [7:0]   reg_addr,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_rdata,
  input wire logic [7:0]   port_low_swing_en,
  input wire logic [7:0]   port_gen2,
  input wire logic [159:0] tx_level,
  input wire logic [95:0]  tx_deemph,
  input wire logic [95:0]  rx_eq_zero,
  input wire logic [95:0]  rx_eq_boost,
  input wire logic [31:0]  rx_eq_en
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // lane 8 is the lane the bench drives to zero and back, so both outcomes are seen
  property p_eq_off;
    rx_eq_en[8] == ((rx_eq_zero[26:24] != 3'h0) || (rx_eq_boost[26:24] != 3'h0));
  endproperty
  a_eq_off: assert property (p_eq_off) else $error("equalizer enable disagrees with zero and boost");

  property p_ls_deemph;
    $past(rst_n) && $past(port_low_swing_en[0]) |-> tx_deemph[11:0] == 12'h000;
  endproperty
  a_ls_deemph: assert property (p_ls_deemph) else $error("de-emphasis active in low swing, serdes 0");

  property p_ls_deemph_top;
    $past(rst_n) && $past(port_low_swing_en[7]) |-> tx_deemph[95:84] == 12'h000;
  endproperty
  a_ls_deemph_top: assert property (p_ls_deemph_top) else $error("de-emphasis active in low swing, serdes 7");

  property p_ls_g1_lvl;
    $past(rst_n) && $past(port_low_swing_en[0]) && !$past(port_gen2[0]) |-> tx_level[4] == 1'h0;
  endproperty
  a_ls_g1_lvl: assert property (p_ls_g1_lvl) else $error("low swing gen 1 level wider than four bits");

  property p_ls_g2_lvl;
    $past(rst_n) && $past(port_low_swing_en[7]) && $past(port_gen2[7]) |-> tx_level[159] == 1'h0;
  endproperty
  a_ls_g2_lvl: assert property (p_ls_g2_lvl) else $error("low swing gen 2 level wider than four bits");

  property p_eqz_rst;
    !$past(rst_n) |-> rx_eq_zero[2:0] == 3'h1;
  endproperty
  a_eqz_rst: assert property (p_eqz_rst) else $error("equalizer zero not at its reset value");

  property p_eqb_rst;
    !$past(rst_n) |-> rx_eq_boost[95:93] == 3'h7;
  endproperty
  a_eqb_rst: assert property (p_eqb_rst) else $error("equalizer boost not at its reset value");

  property p_unmapped_rd;
    $past(reg_rd) && $past(reg_addr[7]) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("read above the eight slots returned data");
endmodule : sltr_regs_chk

bind sltr_regs sltr_regs_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .port_low_swing_en(port_low_swing_en), .port_gen2(port_gen2), .tx_level(tx_level),
  .tx_deemph(tx_deemph), .rx_eq_zero(rx_eq_zero), .rx_eq_boost(rx_eq_boost), .rx_eq_en(rx_eq_en)
);

// [dv/sltr_regs_tb.sv]
// self-checking bench for the lane tuning register bank
// assumes sltr_pkg compiled first; the checker is bound from its own file
`timescale 1ns/1ps

module sltr_regs_tb;
  logic         clk_sys           = 1'h0;
  logic         rst_n             = 1'h0;
  logic [7:0]   reg_addr          = 8'h00;
  logic [31:0]  reg_wdata         = 32'h0000_0000;
  logic         reg_wr            = 1'h0;
  logic         reg_rd            = 1'h0;
  logic [7:0]   port_low_swing_en = 8'h00;
  logic [7:0]   port_deemph_6db   = 8'h00;
  logic [7:0]   port_gen2         = 8'h00;
  logic [31:0]  reg_rdata;
  logic [159:0] tx_level;
  logic [95:0]  tx_deemph;
  logic [95:0]  rx_eq_zero;
  logic [95:0]  rx_eq_boost;
  logic [31:0]  rx_eq_en;
  int           miscompares       = 0;
  int           samples_checked   = 0;
  int           cycles            = 0;
  // low 13 bits hold the gen 1 and -3.5dB level fields that sit outside this bank's rules
  localparam logic [31:0] TXR = {4'hC, 4'hA, 3'h6, 5'h15, 3'h3, sltr_pkg::RST_TX[12:0]};
  localparam logic [31:0] W1  = {4'h3, 4'h5, 3'h2, 5'h0B, 3'h5, 5'h07, 3'h1, 5'h04};

  sltr_regs DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_low_swing_en(port_low_swing_en),
    .port_deemph_6db(port_deemph_6db), .port_gen2(port_gen2), .tx_level(tx_level), .tx_deemph(tx_deemph),
    .rx_eq_zero(rx_eq_zero), .rx_eq_boost(rx_eq_boost), .rx_eq_en(rx_eq_en)
  );

  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'h0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rd

  // outputs are registered, so two edges let both the mode and any write land
  task automatic mode(input logic ls, input logic d6, input logic g2);
    @(posedge clk_sys);
    port_low_swing_en <= {8{ls}};
    port_deemph_6db   <= {8{d6}};
    port_gen2         <= {8{g2}};
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : mode

  task automatic lane(input int n, input logic [4:0] lvl, input logic [2:0] de);
    chk("tx_level", 32'(tx_level[5*n +: 5]), 32'(lvl));
    chk("tx_deemph", 32'(tx_deemph[3*n +: 3]), 32'(de));
  endtask : lane

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd(8'h04, TXR, "tx reset");
    rd(8'h78, 32'h0000_0039, "rx reset");
    rd(8'h70, 32'h0000_000F, "pick reset");
    mode(1'h0, 1'h1, 1'h1);
    lane(0, 5'h15, 3'h6);
    mode(1'h0, 1'h0, 1'h1);
    lane(31, 5'h18, 3'h3);
    mode(1'h1, 1'h0, 1'h0);
    lane(0, 5'h0A, 3'h0);
    mode(1'h1, 1'h1, 1'h1);
    lane(7, 5'h0C, 3'h0);
    end_test("modes");
    wr(8'h10, 32'h0000_0004);
    wr(8'h14, W1);
    rd(8'h14, W1, "picked lane");
    mode(1'h0, 1'h1, 1'h1);
    lane(6, 5'h0B, 3'h2);
    lane(5, 5'h15, 3'h6);
    lane(0, 5'h15, 3'h6);
    mode(1'h1, 1'h0, 1'h1);
    lane(6, 5'h03, 3'h0);
    mode(1'h1, 1'h0, 1'h0);
    lane(6, 5'h05, 3'h0);
    wr(8'h10, 32'h0000_0003);
    rd(8'h14, TXR, "unpicked lane");
    wr(8'h10, 32'h0000_000C);
    rd(8'h14, W1, "lane kept");
    wr(8'h30, 32'h0000_0000);
    wr(8'h34, W1);
    wr(8'h30, 32'h0000_0001);
    rd(8'h34, TXR, "empty pick");
    end_test("lane pick");
    wr(8'h20, 32'h0000_0001);
    wr(8'h28, 32'hFFFF_FFC0);
    rd(8'h28, 32'h0000_0000, "rx off");
    mode(1'h0, 1'h0, 1'h0);
    chk("rx_eq_en", 32'(rx_eq_en[8]), 32'h0000_0000);
    chk("rx_eq_en", 32'(rx_eq_en[9]), 32'h0000_0001);
    wr(8'h28, 32'h0000_0007);
    mode(1'h0, 1'h0, 1'h0);
    chk("rx_eq_zero", 32'(rx_eq_zero[26:24]), 32'h0000_0007);
    chk("rx_eq_boost", 32'(rx_eq_boost[26:24]), 32'h0000_0000);
    chk("rx_eq_en", 32'(rx_eq_en[8]), 32'h0000_0001);
    end_test("equalizer");
    wr(8'h8C, 32'hFFFF_FFFF);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h84, 32'h0000_0000, "above slots");
    rd(8'h0C, 32'h0000_0000, "spare offset");
    rd(8'h04, TXR, "serdes 0 untouched");
    end_test("map");
    final_report();
  end
endmodule : sltr_regs_tb
